// ===== logic/icc_top.sv
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
//Contract
// - Interrupt after 1, 2, 3 or 4 captures per grouping field code; mode 001 interrupts on every capture.
// - Read-only overflow flag set when capture arrives with buffer full.
// - Read-only flag high while any captured value remains unread.
// - Mode 111: wake interrupt on rising edges only, other controls ignored.
// - Mode 110: channel disabled, no captures and no interrupts.
// - Mode 101: capture on every 16th rising edge via prescaler.
module icc_top (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        capture_pin,
    input  wire logic [15:0] timer_a,
    input  wire logic [15:0] timer_b,
    input  wire logic        cpu_idle,
    output logic             irq
);

    typedef struct packed {
        logic [15:0]                 ctrl;
        logic [icc_pkg::IRQ_BITS-1:0] irq_stat;
        logic [icc_pkg::IRQ_BITS-1:0] irq_en;
        logic [icc_pkg::PTR_W-1:0]   wptr;
        logic [icc_pkg::PTR_W-1:0]   rptr;
        logic [2:0]                  count;
        logic                        ovf;
        logic [3:0]                  presc;
        logic [1:0]                  grp;
        logic                        pin_q;
        logic                        rd_pend;
        logic                        rd_avail;
        logic [31:0]                 prdata;
        logic                        pready;
        logic                        pslverr;
        logic                        irq;
    } icc_state_t;

    icc_state_t st;
    icc_state_t next_st;

    logic [15:0] mem_rd;
    logic        mem_wr;
    logic [15:0] cap_val;

    function automatic logic sel(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    icc_buf_mem u_mem (
        .sys_clk (sys_clk),
        .wr_en   (mem_wr),
        .wr_addr (st.wptr),
        .wr_data (cap_val),
        .rd_addr (next_st.rptr),
        .rd_data (mem_rd)
    );

    assign cap_val = st.ctrl[icc_pkg::TMRSEL_BIT] ? timer_b : timer_a;

    always_comb begin
        logic [2:0] mode;
        logic       rise;
        logic       fall;
        logic       edge_hit;
        logic       cap;
        logic       pop;
        logic       acc;
        logic       halted;
        logic       grp_done;
        logic       wake;
        mode     = 3'h0;
        rise     = 1'b0;
        fall     = 1'b0;
        edge_hit = 1'b0;
        cap      = 1'b0;
        pop      = 1'b0;
        acc      = 1'b0;
        halted   = 1'b0;
        grp_done = 1'b0;
        wake     = 1'b0;
        next_st  = st;
        mem_wr   = 1'b0;

        mode   = st.ctrl[icc_pkg::MODE_LSB +: 3];
        rise   = capture_pin & ~st.pin_q;
        fall   = ~capture_pin & st.pin_q;
        halted = cpu_idle & st.ctrl[icc_pkg::SIDL_BIT];
        next_st.pin_q = capture_pin;

        unique case (icc_pkg::icc_mode_t'(mode))
            icc_pkg::ICC_MODE_OFF:    next_st.presc = 4'h0;
            icc_pkg::ICC_MODE_BOTH:   edge_hit = rise | fall;
            icc_pkg::ICC_MODE_FALL:   edge_hit = fall;
            icc_pkg::ICC_MODE_RISE:   edge_hit = rise;
            icc_pkg::ICC_MODE_RISE4: begin
                if (rise) begin
                    edge_hit = st.presc[1:0] == icc_pkg::PRESC_4_LAST[1:0];
                    next_st.presc = st.presc + 4'h1;
                end
            end
            icc_pkg::ICC_MODE_RISE16: begin
                if (rise) begin
                    edge_hit = st.presc == icc_pkg::PRESC_16_LAST;
                    next_st.presc = st.presc + 4'h1;
                end
            end
            icc_pkg::ICC_MODE_UNUSED: next_st.presc = 4'h0;
            icc_pkg::ICC_MODE_WAKE: begin
                wake = rise;
            end
        endcase
        cap = edge_hit & ~halted;

        // APB access phase, two wait states for reads (one for writes) so buffer data is ready
        acc = psel & penable & ~st.pready;
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        if (acc) begin
            if (pwrite) begin
                next_st.pready = 1'b1;
                if (sel(paddr, icc_pkg::CTRL_OFFSET)) begin
                    next_st.ctrl = (st.ctrl & ~icc_pkg::CTRL_WMASK)
                                 | (pwdata[15:0] & icc_pkg::CTRL_WMASK);
                end else if (sel(paddr, icc_pkg::IRQ_EN_OFFSET)) begin
                    next_st.irq_en = pwdata[icc_pkg::IRQ_BITS-1:0];
                end else if (sel(paddr, icc_pkg::IRQ_CLR_OFFSET)) begin
                    next_st.irq_stat = st.irq_stat & ~pwdata[icc_pkg::IRQ_BITS-1:0];
                end else if (!sel(paddr, icc_pkg::BUF_OFFSET)
                             && !sel(paddr, icc_pkg::IRQ_STAT_OFFSET)) begin
                    next_st.pslverr = 1'b1;
                end
            end else if (!st.rd_pend) begin
                next_st.rd_pend  = 1'b1;
                // Only data stored before the read began is already in mem_rd
                next_st.rd_avail = st.count != 3'h0;
            end else begin
                next_st.rd_pend = 1'b0;
                next_st.pready  = 1'b1;
                next_st.prdata  = 32'h0000_0000;
                if (sel(paddr, icc_pkg::CTRL_OFFSET)) begin
                    next_st.prdata[15:0] = st.ctrl;
                    next_st.prdata[icc_pkg::OV_BIT]  = st.ovf;
                    next_st.prdata[icc_pkg::BNE_BIT] = st.count != 3'h0;
                end else if (sel(paddr, icc_pkg::BUF_OFFSET)) begin
                    next_st.prdata[15:0] = mem_rd;
                    pop = st.rd_avail;
                end else if (sel(paddr, icc_pkg::IRQ_STAT_OFFSET)) begin
                    next_st.prdata[icc_pkg::IRQ_BITS-1:0] = st.irq_stat;
                end else if (sel(paddr, icc_pkg::IRQ_EN_OFFSET)) begin
                    next_st.prdata[icc_pkg::IRQ_BITS-1:0] = st.irq_en;
                end else if (!sel(paddr, icc_pkg::IRQ_CLR_OFFSET)) begin
                    next_st.pslverr = 1'b1;
                end
            end
        end

        if (pop) begin
            next_st.rptr = st.rptr + 2'h1;
        end
        if (cap) begin
            if (st.count == icc_pkg::CNT_FULL && !pop) begin
                next_st.ovf = 1'b1;
                next_st.irq_stat[icc_pkg::IRQ_OV_BIT] = 1'b1;
            end else begin
                mem_wr = 1'b1;
                next_st.wptr = st.wptr + 2'h1;
            end
        end
        next_st.count = st.count + {2'h0, mem_wr} - {2'h0, pop};
        // Overflow clears once software drains the buffer or turns it off
        if (st.ovf && (next_st.count == 3'h0 || mode == icc_pkg::ICC_MODE_OFF)) begin
            next_st.ovf = 1'b0;
        end
        if (mode == icc_pkg::ICC_MODE_OFF) begin
            next_st.wptr  = 2'h0;
            next_st.rptr  = 2'h0;
            next_st.count = 3'h0;
            next_st.grp   = 2'h0;
        end

        if (cap) begin
            grp_done = (mode == icc_pkg::ICC_MODE_BOTH)
                    || (st.grp == st.ctrl[icc_pkg::CPI_LSB +: 2]);
            next_st.grp = grp_done ? 2'h0 : st.grp + 2'h1;
            if (grp_done) begin
                next_st.irq_stat[icc_pkg::IRQ_CAP_BIT] = 1'b1;
            end
        end
        // Set after the clear write so a same-cycle wake event wins
        if (wake) begin
            next_st.irq_stat[icc_pkg::IRQ_WAKE_BIT] = 1'b1;
        end

        next_st.irq = |(next_st.irq_stat & next_st.irq_en);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st        <= '0;
            st.ctrl   <= icc_pkg::CTRL_RESET;
            st.irq_en <= icc_pkg::IRQ_EN_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign prdata  = st.prdata;
    assign pready  = st.pready;
    assign pslverr = st.pslverr;
    assign irq     = st.irq;

endmodule

// ===== common/icc_pkg.sv
package icc_pkg;

    // Register byte offsets on APB
    localparam logic [11:0] CTRL_OFFSET      = 12'h000;
    localparam logic [11:0] BUF_OFFSET       = 12'h004;
    localparam logic [11:0] IRQ_STAT_OFFSET  = 12'h008;
    localparam logic [11:0] IRQ_EN_OFFSET    = 12'h00c;
    localparam logic [11:0] IRQ_CLR_OFFSET   = 12'h010;

    // Control register field positions
    localparam int MODE_LSB   = 0;
    localparam int BNE_BIT    = 3;
    localparam int OV_BIT     = 4;
    localparam int CPI_LSB    = 5;
    localparam int TMRSEL_BIT = 7;
    localparam int SIDL_BIT   = 13;

    // Interrupt status bit positions
    localparam int IRQ_CAP_BIT  = 0;
    localparam int IRQ_OV_BIT   = 1;
    localparam int IRQ_WAKE_BIT = 2;
    localparam int IRQ_BITS     = 3;

    localparam logic [15:0] CTRL_RESET     = 16'h0000;
    localparam logic [15:0] CTRL_WMASK     = 16'h20e7;
    localparam logic [2:0]  IRQ_EN_RESET   = 3'h0;

    // Buffer depth
    localparam int          BUF_DEPTH  = 4;
    localparam int          PTR_W      = 2;
    localparam logic [2:0]  CNT_FULL   = 3'h4;

    localparam logic [3:0]  PRESC_16_LAST = 4'hf;
    localparam logic [3:0]  PRESC_4_LAST  = 4'h3;

    typedef enum logic [2:0] {
        ICC_MODE_OFF     = 3'b000,
        ICC_MODE_BOTH    = 3'b001,
        ICC_MODE_FALL    = 3'b010,
        ICC_MODE_RISE    = 3'b011,
        ICC_MODE_RISE4   = 3'b100,
        ICC_MODE_RISE16  = 3'b101,
        ICC_MODE_UNUSED  = 3'b110,
        ICC_MODE_WAKE    = 3'b111
    } icc_mode_t;

endpackage

// ===== logic/icc_buf_mem.sv
`timescale 1ns/1ns
module icc_buf_mem (
    input  wire logic                      sys_clk,
    input  wire logic                      wr_en,
    input  wire logic [icc_pkg::PTR_W-1:0] wr_addr,
    input  wire logic [15:0]               wr_data,
    input  wire logic [icc_pkg::PTR_W-1:0] rd_addr,
    output logic      [15:0]               rd_data
);
    logic [15:0] mem [icc_pkg::BUF_DEPTH];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ===== bench/icc_pin_model.sv
`timescale 1ns/1ns
module icc_pin_model (
    input  wire logic sys_clk,
    output logic      capture_pin
);
    initial capture_pin = 1'b0;
    // Gap sets how slowly the far side moves
    task automatic edges(input int n, input int gap);
        repeat (n) begin
            repeat (gap) @(posedge sys_clk);
            capture_pin <= ~capture_pin;
        end
    endtask
endmodule

// ===== bench/icc_top_assertions.sv
`timescale 1ns/1ns
module icc_top_assertions (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        capture_pin,
    input wire logic        irq
);
    logic [6:0] ctl;
    logic [2:0] en;
    logic [3:0] rc;
    logic       pv;
    logic       wr;
    logic [2:0] m;
    logic       q;
    logic       rs;
    assign wr = psel & penable & pwrite & ~pready;
    assign m  = ctl[2:0];
    assign q  = !psel && !irq;
    assign rs = capture_pin & ~pv;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Shadow of control and enable, and rising edges seen since off or mode 110
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctl <= 7'h00;
            en  <= 3'h0;
            rc  <= 4'h0;
            pv  <= 1'b0;
        end else begin
            if (wr && paddr == icc_pkg::CTRL_OFFSET) ctl <= pwdata[6:0];
            if (wr && paddr == icc_pkg::IRQ_EN_OFFSET) en <= pwdata[2:0];
            rc <= (m == 3'h0 || m == 3'h6) ? 4'h0 : rc + 4'(rs);
            pv <= capture_pin;
        end
    end
    sequence s_quiet;
        !irq [*2];
    endsequence
    a_off_quiet: assert property (m == 3'h0 && q |=> !irq)
        else $error("irq while off");
    a_unused_quiet: assert property (m == 3'h6 && q |=> !irq)
        else $error("irq in unused mode");
    a_wake_irq: assert property (m == 3'h7 && en[2] && rs |-> ##[1:3] irq)
        else $error("no wake irq");
    a_rise_irq: assert property (m == 3'h3 && ctl[6:5] == 2'h0 && en[0] && rs
        |-> ##[1:3] irq) else $error("no irq on rise");
    a_both_irq: assert property (m == 3'h1 && en[0] && (capture_pin ^ pv)
        |-> ##[1:3] irq) else $error("no irq on edge");
    a_group_wait: assert property (m == 3'h3 && ctl[6:5] == 2'h3 && q && rs
        && rc[1:0] != 2'h3 |=> s_quiet) else $error("early group irq");
    a_pre16_wait: assert property (m == 3'h5 && q && rs && rc != 4'hf
        |=> s_quiet) else $error("capture before 16th rise");
endmodule
bind icc_top icc_top_assertions chk_u (.sys_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .capture_pin, .irq);

// ===== bench/tb.sv
`timescale 1ns/1ns
module tb;
    localparam logic [11:0] ct = icc_pkg::CTRL_OFFSET;
    localparam logic [11:0] bf = icc_pkg::BUF_OFFSET;
    localparam logic [11:0] st = icc_pkg::IRQ_STAT_OFFSET;
    localparam logic [11:0] ie = icc_pkg::IRQ_EN_OFFSET;
    localparam logic [11:0] cl = icc_pkg::IRQ_CLR_OFFSET;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        capture_pin;
    logic [15:0] timer_a = 16'h1234;
    logic [15:0] timer_b = 16'hbeef;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cnt [8] = '{0, 32, 16, 16, 4, 1, 0, 0};
    int          n;
    always #20 sys_clk = ~sys_clk;
    icc_top dut_u (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .capture_pin, .timer_a, .timer_b, .cpu_idle(1'b0), .irq);
    icc_pin_model pm_u (.sys_clk, .capture_pin);
    task automatic results;
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            results();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string s);
        xfer(1'b0, a, 32'h0);
        chk(s, e, rd);
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rdc(ct, 32'h0, "ctrl reset");
        xfer(1'b0, 12'h014, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        $display("test reset done");
        xfer(1'b1, ie, 32'h1);
        xfer(1'b1, ct, 32'h63);
        pm_u.edges(6, 4);
        repeat (4) @(posedge sys_clk);
        chk("irq early", 32'h0, {31'h0, irq});
        pm_u.edges(2, 4);
        repeat (4) @(posedge sys_clk);
        chk("irq group", 32'h1, {31'h0, irq});
        repeat (4) rdc(bf, {16'h0, timer_a}, "buf a");
        rdc(ct, 32'h63, "ctrl empty");
        xfer(1'b1, cl, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk("irq clear", 32'h0, {31'h0, irq});
        $display("test grouping done");
        xfer(1'b1, ie, 32'h7);
        // Every mode, 16 rises and 16 falls, timer b, read-only bits poked
        for (int m = 0; m < 8; m++) begin
            xfer(1'b1, ct, 32'h0);
            xfer(1'b1, cl, 32'h7);
            xfer(1'b1, ct, 32'h98 | m);
            pm_u.edges(32, 4);
            repeat (4) @(posedge sys_clk);
            n = cnt[m];
            rdc(ct, 32'h80 | m | (n > 4) << 4 | (n > 0) << 3, "ctrl");
            rdc(st, 32'h0 | (m == 7) << 2 | (n > 4) << 1 | (n > 0), "stat");
            repeat (n > 4 ? 4 : n) rdc(bf, {16'h0, timer_b}, "buf b");
            rdc(ct, 32'h80 | m, "drained");
            $display("test mode %0d done", m);
        end
        results();
    end
endmodule
